/* File: common/lsu_pkg.sv */
// Package for the single load/store unit: fields, constants and carriers.
// Assumes a 32-bit data bus and a decoded instruction from the core.
package lsu_pkg;
	localparam int          INSN_W     = 32;
	localparam logic [3:0]  PC_REG_NUM = 4'hF;
	localparam logic [31:0] PC_BASE_ADJ  = 32'h0000_0008;
	localparam logic [31:0] PC_STORE_ADJ = 32'h0000_000C;
	localparam int          IMM_LSB    = 0;
	localparam int          IMM_W      = 12;
	localparam int          SH_AMT_LSB = 7;
	localparam int          SH_TYP_LSB = 5;
	localparam int          SH_REG_BIT = 4;
	localparam int          OFFREG_LSB = 0;
	localparam int          SRCREG_LSB = 12;
	localparam int          BASEREG_LSB = 16;
	localparam int          L_BIT      = 20;
	localparam int          W_BIT      = 21;
	localparam int          B_BIT      = 22;
	localparam int          U_BIT      = 23;
	localparam int          P_BIT      = 24;
	localparam int          I_BIT      = 25;
	localparam logic [1:0]  SH_LSL = 2'h0;
	localparam logic [1:0]  SH_LSR = 2'h1;
	localparam logic [1:0]  SH_ASR = 2'h2;
	localparam logic [1:0]  SH_ROR = 2'h3;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        write;
		logic        byte_sel;
		logic        user_mode;
	} lsu_mem_req_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  num;
		logic [31:0] value;
	} lsu_reg_wr_t;

	typedef enum logic [1:0] {
		LSU_IDLE,
		LSU_DATA,
		LSU_INTERNAL
	} lsu_state_t;
endpackage

/* File: hdl/lsu_core.sv */
// Single word/byte load-store execution: address generation, lane steering.
// Assumes register values are supplied with the instruction and that the
// memory answers a request with done or abort, synchronous to ref_clk.
// Function
// R01 - Offset is a 12-bit immediate or a possibly shifted register.
// R02 - Up bit one adds offset to base, zero subtracts it.
// R03 - Pre-index uses modified base; post-index uses unmodified base.
// R04 - Pre-indexed writes modified base back only when write-back bit set.
// R05 - Post-indexed transfers always write the modified base back.
// R06 - Privileged post-index with write-back bit forces user mode for transfer.
// R07 - Register offset shift uses immediate amounts only, never a register.
// R08 - Byte bit one gives byte transfer, zero gives word transfer.
// R09 - Internal lane positions stay those of 32-bit memory always.
// R10 - Little-endian byte load picks lane by address, zero-extends.
// R11 - Byte store replicates low source byte into all four lanes.
// R12 - Little-endian unaligned word load rotates addressed byte to bits 7..0.
// R13 - Word store drives the register unrotated.
// R14 - Big-endian byte load picks lane 31..24 first, zero-extends.
// R15 - Big-endian word load rotates addressed byte to 31..24 or 15..8.
// R16 - Program counter base reads instruction address plus eight.
// R17 - Producer never names the program counter as offset register.
// R18 - Storing the program counter writes instruction address plus twelve.
// R19 - Producer never issues post-index with offset register equal to base.
// R20 - Memory abort accepted on any transfer; nothing written, restartable.
// R21 - Load takes one data cycle and one internal cycle.
// R22 - Immediate offset is zero-extended to 32 bits.
`timescale 1ns/1ns
module lsu_core
	import lsu_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         srst,
	input  wire logic         clk_en,
	input  wire logic         big_endian,
	input  wire logic         privileged,
	input  wire logic         start,
	input  wire logic [31:0]  insn,
	input  wire logic [31:0]  insn_addr,
	input  wire logic [31:0]  base_value,
	input  wire logic [31:0]  offset_value,
	input  wire logic [31:0]  source_value,
	input  wire logic [31:0]  mem_rdata,
	input  wire logic         mem_done,
	input  wire logic         mem_abort,
	output lsu_mem_req_t      mem_req_ff,
	output logic              mem_valid_ff,
	output lsu_reg_wr_t       base_wr_ff,
	output lsu_reg_wr_t       dest_wr_ff,
	output logic              busy_ff,
	output logic              abort_ff
);
	function automatic logic [31:0] shift_imm(input logic [31:0] v,
		input logic [1:0] typ, input logic [4:0] amt);
		logic [32:0] tmp;
		tmp = 33'h0_0000_0000;
		case (typ)
			SH_LSL: shift_imm = v << amt;
			SH_LSR: shift_imm = (amt == 5'h00) ? 32'h0000_0000 : v >> amt;
			SH_ASR: begin
				tmp = {v[31], v};
				shift_imm = (amt == 5'h00) ? {32{v[31]}} :
					32'(($signed(tmp)) >>> amt);
			end
			default: shift_imm = (v >> amt) | (v << (6'h20 - {1'b0, amt}));
		endcase
	endfunction

	function automatic logic [31:0] rot_right(input logic [31:0] v,
		input logic [4:0] amt);
		rot_right = (v >> amt) | (v << (6'h20 - {1'b0, amt}));
	endfunction

	lsu_state_t   state_ff, nxt_state;
	lsu_mem_req_t nxt_mem_req;
	lsu_reg_wr_t  nxt_base_wr, nxt_dest_wr, pend_dest_ff, nxt_pend_dest;
	lsu_reg_wr_t  pend_base_ff, nxt_pend_base;
	logic         nxt_mem_valid, nxt_busy, nxt_abort;
	logic [31:0]  base_eff, offset, mod_base, xfer_addr, store_data;
	logic [31:0]  load_word, load_byte, load_data;
	logic [1:0]   lane;
	logic         do_wb;

	always_comb begin
		// R16 pc base adjust
		base_eff = (insn[BASEREG_LSB +: 4] == PC_REG_NUM) ?
			insn_addr + PC_BASE_ADJ : base_value;
		// R01 offset select
		// R22 zero extend immediate
		// R07 immediate shift only
		// R17 offset reg trusted
		if (!insn[I_BIT])
			offset = {20'h0_0000, insn[IMM_LSB +: IMM_W]};
		else
			offset = shift_imm(offset_value, insn[SH_TYP_LSB +: 2],
				insn[SH_AMT_LSB +: 5]);
		// R02 add or subtract
		mod_base = insn[U_BIT] ? base_eff + offset : base_eff - offset;
		// R03 pre or post
		xfer_addr = insn[P_BIT] ? mod_base : base_eff;
		// R04 pre write-back
		// R05 post write-back
		// R19 no base reuse
		do_wb = !insn[P_BIT] || insn[W_BIT];
		// R18 pc store value
		store_data = (insn[SRCREG_LSB +: 4] == PC_REG_NUM) ?
			insn_addr + PC_STORE_ADJ : source_value;
		// R11 byte replicate
		// R13 word unrotated
		if (insn[B_BIT])
			store_data = {4{store_data[7:0]}};
	end

	always_comb begin
		// R09 internal lanes
		lane = big_endian ? 2'h3 - mem_req_ff.addr[1:0] : mem_req_ff.addr[1:0];
		// R10 le byte lane
		// R14 be byte lane
		load_byte = {24'h00_0000, mem_rdata[{lane, 3'h0} +: 8]};
		// R12 le rotate
		// R15 be rotate
		// Rotation follows the byte offset alike in both modes; only the lane
		// of the addressed byte differs, and the rotation carries it along.
		load_word = rot_right(mem_rdata, {mem_req_ff.addr[1:0], 3'h0});
		// R08 byte or word
		load_data = mem_req_ff.byte_sel ? load_byte : load_word;
	end

	always_comb begin
		nxt_state     = state_ff;
		nxt_mem_req   = mem_req_ff;
		nxt_mem_valid = mem_valid_ff;
		nxt_base_wr   = '0;
		nxt_dest_wr   = '0;
		nxt_pend_dest = pend_dest_ff;
		nxt_pend_base = pend_base_ff;
		nxt_busy      = busy_ff;
		nxt_abort     = 1'b0;
		case (state_ff)
			LSU_IDLE: begin
				if (start) begin
					nxt_mem_req.addr      = xfer_addr;
					nxt_mem_req.wdata     = store_data;
					nxt_mem_req.write     = !insn[L_BIT];
					nxt_mem_req.byte_sel  = insn[B_BIT];
					// R06 forced user mode
					nxt_mem_req.user_mode = !privileged ||
						(!insn[P_BIT] && insn[W_BIT]);
					nxt_mem_valid      = 1'b1;
					nxt_pend_base.valid = do_wb;
					nxt_pend_base.num  = insn[BASEREG_LSB +: 4];
					nxt_pend_base.value = mod_base;
					nxt_pend_dest.valid = insn[L_BIT];
					nxt_pend_dest.num  = insn[SRCREG_LSB +: 4];
					nxt_busy           = 1'b1;
					nxt_state          = LSU_DATA;
				end
			end
			LSU_DATA: begin
				// R20 abort restartable
				if (mem_abort) begin
					nxt_mem_valid = 1'b0;
					nxt_abort     = 1'b1;
					nxt_busy      = 1'b0;
					nxt_state     = LSU_IDLE;
				end else if (mem_done) begin
					nxt_mem_valid       = 1'b0;
					nxt_pend_dest.value = load_data;
					nxt_base_wr         = pend_base_ff;
					// R21 internal cycle
					nxt_state = pend_dest_ff.valid ? LSU_INTERNAL : LSU_IDLE;
					nxt_busy  = pend_dest_ff.valid;
				end
			end
			default: begin
				nxt_dest_wr = pend_dest_ff;
				nxt_busy    = 1'b0;
				nxt_state   = LSU_IDLE;
			end
		endcase
	end

	// The clock enable freezes every flop, including the one-cycle pulses.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_ff     <= LSU_IDLE;
			mem_req_ff   <= '0;
			mem_valid_ff <= 1'b0;
			base_wr_ff   <= '0;
			dest_wr_ff   <= '0;
			pend_dest_ff <= '0;
			pend_base_ff <= '0;
			busy_ff      <= 1'b0;
			abort_ff     <= 1'b0;
		end else if (clk_en) begin
			state_ff     <= nxt_state;
			mem_req_ff   <= nxt_mem_req;
			mem_valid_ff <= nxt_mem_valid;
			base_wr_ff   <= nxt_base_wr;
			dest_wr_ff   <= nxt_dest_wr;
			pend_dest_ff <= nxt_pend_dest;
			pend_base_ff <= nxt_pend_base;
			busy_ff      <= nxt_busy;
			abort_ff     <= nxt_abort;
		end
	end

	// R20 no update on abort
	chk_abort_no_wb: assert property ( // R20
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_DATA && mem_abort |=>
		!base_wr_ff.valid ##1 !dest_wr_ff.valid)
		else $error("Register written after abort.");
	// R21 result after internal
	chk_load_timing: assert property ( // R21
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_DATA && mem_done && !mem_abort &&
		pend_dest_ff.valid ##1 clk_en |=> dest_wr_ff.valid)
		else $error("Load result not written one cycle after data.");
	// R05 post always writes
	chk_post_wb: assert property ( // R05
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start && !insn[P_BIT] |=>
		pend_base_ff.valid)
		else $error("Post-indexed transfer lost write-back.");
	// R04 pre follows bit
	chk_pre_wb: assert property ( // R04
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start && insn[P_BIT] |=>
		pend_base_ff.valid == $past(insn[W_BIT]))
		else $error("Pre-indexed write-back does not follow W.");
	// R06 forced user mode
	chk_user_force: assert property ( // R06
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start && privileged &&
		!insn[P_BIT] && insn[W_BIT] |=> mem_req_ff.user_mode)
		else $error("Forced user mode missing.");
	// R11 byte lanes 31..24 and 15..8 replicated
	chk_byte_store: assert property ( // R11
		@(posedge ref_clk) disable iff (srst)
		mem_valid_ff && mem_req_ff.write && mem_req_ff.byte_sel |->
		mem_req_ff.wdata[31:24] == mem_req_ff.wdata[7:0] &&
		mem_req_ff.wdata[15:8] == mem_req_ff.wdata[7:0])
		else $error("Byte store lanes not replicated.");
	// R10 byte zero extension
	chk_byte_zero: assert property ( // R10
		@(posedge ref_clk) disable iff (srst)
		dest_wr_ff.valid && mem_req_ff.byte_sel |->
		dest_wr_ff.value[31:8] == 24'h00_0000)
		else $error("Byte load not zero-extended.");
	// R03 address selection
	chk_addr_pre: assert property ( // R03
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start |=>
		mem_req_ff.addr == $past(xfer_addr) &&
		(!pend_base_ff.valid || pend_base_ff.value == $past(mod_base)))
		else $error("Transfer address or base value wrong.");
	// R16 program counter base
	chk_pc_base: assert property ( // R16
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start && insn[P_BIT] &&
		insn[U_BIT] && !insn[I_BIT] &&
		insn[BASEREG_LSB +: 4] == PC_REG_NUM |=>
		mem_req_ff.addr == $past(insn_addr) + PC_BASE_ADJ +
		$past({20'h0_0000, insn[IMM_LSB +: IMM_W]}))
		else $error("Program counter base not eight bytes ahead.");
	// R18 program counter store
	chk_pc_store: assert property ( // R18
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start && !insn[L_BIT] &&
		!insn[B_BIT] && insn[SRCREG_LSB +: 4] == PC_REG_NUM |=>
		mem_req_ff.wdata == $past(insn_addr) + PC_STORE_ADJ)
		else $error("Stored program counter not twelve bytes ahead.");
	// R13 word store unrotated
	chk_word_store: assert property ( // R13
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start && !insn[L_BIT] &&
		!insn[B_BIT] && insn[SRCREG_LSB +: 4] != PC_REG_NUM |=>
		mem_req_ff.wdata == $past(source_value))
		else $error("Word store data altered.");
	// R22 immediate offset extended
	chk_imm_offset: assert property ( // R22
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start && insn[P_BIT] &&
		!insn[I_BIT] && insn[BASEREG_LSB +: 4] != PC_REG_NUM |=>
		mem_req_ff.addr == ($past(insn[U_BIT]) ?
		$past(base_value) + $past({20'h0_0000, insn[IMM_LSB +: IMM_W]}) :
		$past(base_value) - $past({20'h0_0000, insn[IMM_LSB +: IMM_W]})))
		else $error("Immediate offset not applied as unsigned.");
	// R08 byte or word
	chk_size_kind: assert property ( // R08
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_IDLE && start |=>
		mem_req_ff.byte_sel == $past(insn[B_BIT]) &&
		mem_req_ff.write == !$past(insn[L_BIT]))
		else $error("Transfer size or direction wrong.");
	// R21 request held waiting
	chk_req_stable: assert property ( // R21
		@(posedge ref_clk) disable iff (srst)
		mem_valid_ff && !mem_done && !mem_abort |=>
		mem_valid_ff && $stable(mem_req_ff))
		else $error("Request changed before its answer.");
	// R20 abort ends transfer
	chk_abort_idle: assert property ( // R20
		@(posedge ref_clk) disable iff (srst)
		abort_ff |-> !busy_ff && !mem_valid_ff)
		else $error("Transfer still open after abort.");
	// R21 single data cycle
	chk_done_drop: assert property ( // R21
		@(posedge ref_clk) disable iff (srst)
		clk_en && state_ff == LSU_DATA && mem_done |=> !mem_valid_ff)
		else $error("Request still valid after its answer.");
	cov_load: cover property (@(posedge ref_clk) dest_wr_ff.valid);
	cov_store: cover property (@(posedge ref_clk)
		mem_valid_ff && mem_req_ff.write && mem_done);
	cov_abort: cover property (@(posedge ref_clk) abort_ff);
	cov_be_unaligned: cover property (@(posedge ref_clk)
		dest_wr_ff.valid && big_endian && !mem_req_ff.byte_sel &&
		mem_req_ff.addr[0]);
	cov_forced_user: cover property (@(posedge ref_clk)
		mem_valid_ff && privileged && mem_req_ff.user_mode);
endmodule

/* File: tb/lsu_mem_model.sv */
// Memory and MMU stand-in: answers each request after a commanded wait.
// Assumes the bench sets lat and abt at least one cycle before a request.
`timescale 1ns/1ns
module lsu_mem_model
	import lsu_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         mem_valid_ff,
	input  wire lsu_mem_req_t mem_req_ff,
	input  wire logic [1:0]   lat,
	input  wire logic         abt,
	output logic [31:0]       mem_rdata,
	output logic              mem_done,
	output logic              mem_abort
);
	logic [1:0] wait_ff = 2'h0;
	initial begin
		mem_rdata = 32'h0;
		mem_done = 1'b0;
		mem_abort = 1'b0;
	end
	// Idle read data flips each cycle so a stale capture cannot pass.
	always @(negedge ref_clk) begin
		if (mem_done || mem_abort || !mem_valid_ff) begin
			mem_done <= 1'b0;
			mem_abort <= 1'b0;
			wait_ff <= lat;
			mem_rdata <= ~mem_rdata;
		end else if (wait_ff != 2'h0) begin
			wait_ff <= wait_ff - 2'h1;
			mem_rdata <= ~mem_rdata;
		end else begin
			mem_done <= !abt;
			mem_abort <= abt;
			mem_rdata <= {mem_req_ff.addr[31:2], 2'h0} ^ 32'h5A3C_C3A5;
		end
	end
endmodule

/* File: tb/tb_lsu_core.sv */
// Random single transfers against the memory model, checked from queues.
// Assumes the design only answers on ref_clk and that clk_en freezes it.
`timescale 1ns/1ns
module tb_lsu_core
	import lsu_pkg::*;
;
	logic         ref_clk, srst, clk_en, big_endian, privileged, start;
	logic         mem_done, mem_abort, abt, mem_valid_ff, busy_ff, abort_ff;
	logic [1:0]   lat;
	logic [31:0]  insn, insn_addr, base_value, offset_value, source_value;
	logic [31:0]  mem_rdata;
	lsu_mem_req_t mem_req_ff, er, sr;
	lsu_reg_wr_t  base_wr_ff, dest_wr_ff;
	lsu_mem_req_t q_req[$];
	lsu_reg_wr_t  q_bw[$], q_dw[$];
	int           q_ab = 0, errors = 0, n_compared = 0, cyc = 0, t_done = 0;
	int           seed = 44821;
	lsu_core u_dut (.ref_clk, .srst, .clk_en, .big_endian, .privileged,
		.start, .insn, .insn_addr, .base_value, .offset_value, .source_value,
		.mem_rdata, .mem_done, .mem_abort, .mem_req_ff, .mem_valid_ff,
		.base_wr_ff, .dest_wr_ff, .busy_ff, .abort_ff);
	lsu_mem_model u_mem (.ref_clk, .mem_valid_ff, .mem_req_ff, .lat, .abt,
		.mem_rdata, .mem_done, .mem_abort);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [127:0] s, e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic op();
		logic [31:0] b, o, m, a, w, s;
		logic [5:0]  sa;
		logic [1:0]  ln;
		sa = (insn[11:7] == 5'h0) ? 6'h20 : {1'h0, insn[11:7]};
		case ({insn[I_BIT], insn[6:5]})
			3'h4: o = offset_value << insn[11:7];
			3'h5: o = offset_value >> sa;
			3'h6: o = $signed(offset_value) >>> sa;
			3'h7: o = 32'({offset_value, offset_value} >> insn[11:7]);
			default: o = {20'h0, insn[11:0]};
		endcase
		b = insn[19:16] == PC_REG_NUM ? insn_addr + PC_BASE_ADJ : base_value;
		s = insn[15:12] == PC_REG_NUM ? insn_addr + PC_STORE_ADJ : source_value;
		m = insn[U_BIT] ? b + o : b - o;
		a = insn[P_BIT] ? m : b;
		q_req.push_back('{a, insn[B_BIT] ? {4{s[7:0]}} : s, !insn[L_BIT],
			insn[B_BIT], !privileged || (!insn[P_BIT] && insn[W_BIT])});
		if (abt) q_ab++;
		else begin
			if (!insn[P_BIT] || insn[W_BIT])
				q_bw.push_back('{1'b1, insn[19:16], m});
			ln = big_endian ? 2'h3 - a[1:0] : a[1:0];
			w = {a[31:2], 2'h0} ^ 32'h5A3C_C3A5;
			w = 32'({w, w} >> (8 * (insn[B_BIT] ? ln : a[1:0])));
			if (insn[B_BIT]) w = {24'h0, w[7:0]};
			if (insn[L_BIT]) q_dw.push_back('{1'b1, insn[15:12], w});
		end
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		for (int i = 0; i < 20 && busy_ff !== 1'b0; i++) @(negedge ref_clk);
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + clk_en;
		if (cyc > 20000) begin
			errors++;
			summarize();
		end
		if (!srst && clk_en) begin
			if (mem_valid_ff && (mem_done || mem_abort)) begin
				t_done = cyc;
				er = q_req.pop_front();
				sr = mem_req_ff;
				if (!er.write) {er.wdata, sr.wdata} = 64'h0;
				chk("mem_req", sr, er);
			end
			if (base_wr_ff.valid === 1'b1)
				chk("base_wr", base_wr_ff, q_bw.pop_front());
			if (dest_wr_ff.valid === 1'b1) begin
				chk("dest_wr", dest_wr_ff, q_dw.pop_front());
				chk("load_cycles", cyc - t_done, 2);
			end
			if (abort_ff === 1'b1) begin
				chk("abort", q_ab > 0, 1);
				q_ab--;
			end
		end
	end
	initial begin
		{srst, clk_en, start, abt, lat, big_endian, privileged} = 8'h C0;
		{insn, insn_addr, base_value, offset_value, source_value} = 160'h0;
		repeat (8) @(negedge ref_clk);
		srst = 1'b0;
		chk("reset", {mem_valid_ff, busy_ff, abort_ff, base_wr_ff.valid}, 0);
		for (int k = 0; k < 500; k++) begin
			clk_en = 1'b0;
			insn = {6'h39, 26'($random(seed))};
			// offset register never pc nor base
			insn[3:0] = {1'b0, ~insn[18:16]};
			insn[SH_REG_BIT] = 1'b0;
			if (insn[19:16] == PC_REG_NUM) {insn[P_BIT], insn[W_BIT]} = 2'h2;
			if (insn[15:12] == PC_REG_NUM && (insn[L_BIT] || insn[B_BIT]))
				insn[12] = 1'b0;
			base_value = $random(seed);
			offset_value = $random(seed);
			source_value = $random(seed);
			insn_addr = {30'($random(seed)), 2'h0};
			{big_endian, privileged, lat} = 4'($random(seed));
			abt = 3'($random(seed)) == 3'h0;
			@(negedge ref_clk);
			clk_en = 1'b1;
			op();
			if (abt) begin
				abt = 1'b0;
				@(negedge ref_clk);
				op();
			end
		end
		repeat (4) @(negedge ref_clk);
		chk("pending", q_req.size() + q_bw.size() + q_dw.size() + q_ab, 0);
		summarize();
	end
endmodule
